// >>> core/camn_regs.vh
`ifndef CAMN_REGS_VH
`define CAMN_REGS_VH

// Register byte offsets.
`define CAMN_OFF_PICK     12'h000
`define CAMN_OFF_NOTIFY   12'h004
`define CAMN_OFF_LINE_INV 12'h008
`define CAMN_OFF_LINE_LVL 12'h00c
`define CAMN_OFF_STATUS   12'h010
`define CAMN_OFF_MASK     12'h014
`define CAMN_OFF_MSG_CNT  12'h018
`define CAMN_OFF_LOST_CNT 12'h01c

// Status bit positions.
`define CAMN_ST_SENT      0
`define CAMN_ST_LOST      1
`define CAMN_ST_W         2

// Notification enable encodings.
`define CAMN_NOTE_OFF     2'h0
`define CAMN_NOTE_ON      2'h1
`define CAMN_NOTE_LEGACY  2'h2

// Event type codes, also the selector values.
`define CAMN_EV_ACQ_TRIG   5'h00
`define CAMN_EV_ACQ_BEGIN  5'h01
`define CAMN_EV_ACQ_DONE   5'h02
`define CAMN_EV_ACQ_XBEGIN 5'h03
`define CAMN_EV_ACQ_XDONE  5'h04
`define CAMN_EV_ACQ_FAULT  5'h05
`define CAMN_EV_FRM_TRIG   5'h06
`define CAMN_EV_FRM_BEGIN  5'h07
`define CAMN_EV_FRM_DONE   5'h08
`define CAMN_EV_FRM_XBEGIN 5'h09
`define CAMN_EV_FRM_XDONE  5'h0a
`define CAMN_EV_EXP_BEGIN  5'h0b
`define CAMN_EV_EXP_DONE   5'h0c
`define CAMN_EV_CNT_BASE   5'h0d
`define CAMN_EV_TMR_BASE   5'h11
`define CAMN_EV_LINE_BASE  5'h15
`define CAMN_EV_ERROR      5'h1b
`define CAMN_EV_ERROR_OLD  5'h1c
`define CAMN_NUM_EV        29

// Sizes.
`define CAMN_NUM_CNT      2
`define CAMN_NUM_TMR      2
`define CAMN_NUM_LINE     2
`define CAMN_TS_W         32
`define CAMN_FID_W        16
`define CAMN_ECODE_W      8

`endif

// >>> core/camn_notifier.v
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
`include "camn_regs.vh"

module camn_notifier (
  // Clock and reset.
  input  wire                      sys_clk,
  input  wire                      sys_rst,
  // APB slave.
  input  wire                      psel,
  input  wire                      penable,
  input  wire                      pwrite,
  input  wire [11:0]               paddr,
  input  wire [31:0]               pwdata,
  output reg  [31:0]               prdata,
  output reg                       pready,
  output reg                       pslverr,
  // Acquisition and frame occurrences, one-cycle pulses.
  input  wire                      acq_trigger,
  input  wire                      acq_begin,
  input  wire                      acq_done,
  input  wire                      acq_xfer_begin,
  input  wire                      acq_xfer_done,
  input  wire                      acquire_fault,
  input  wire                      frame_trigger,
  input  wire                      frame_begin,
  input  wire                      frame_done,
  input  wire                      frame_xfer_begin,
  input  wire                      frame_xfer_done,
  input  wire                      exposure_begin,
  input  wire                      exposure_done,
  // Counters and timers, bit 0 is number one.
  input  wire [`CAMN_NUM_CNT-1:0]  counter_begin,
  input  wire [`CAMN_NUM_CNT-1:0]  counter_done,
  input  wire [`CAMN_NUM_TMR-1:0]  timer_begin,
  input  wire [`CAMN_NUM_TMR-1:0]  timer_done,
  // Raw input lines, bit 0 is line zero.
  input  wire [`CAMN_NUM_LINE-1:0] line_in,
  // Error reporting.
  input  wire                      device_error,
  input  wire [`CAMN_ECODE_W-1:0]  error_code,
  // Current frame identifier from the acquisition path.
  input  wire [`CAMN_FID_W-1:0]    frame_identifier,
  // Message port toward the transport.
  input  wire                      msg_ready,
  output reg                       msg_valid,
  output reg  [4:0]                msg_type,
  output reg  [`CAMN_TS_W-1:0]     msg_timestamp,
  output reg  [`CAMN_FID_W-1:0]    msg_frame_id,
  output reg  [`CAMN_ECODE_W-1:0]  msg_data,
  // Interrupt and line levels.
  output reg                       irq,
  output reg  [`CAMN_NUM_LINE-1:0] line_level_view
);

  localparam NEV = `CAMN_NUM_EV;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers.

  // Index of the lowest set bit, zero when none.
  function [4:0] first_set;
    input [NEV-1:0] v;
    integer k;
    begin
      first_set = 5'h00;
      for (k = NEV - 1; k >= 0; k = k - 1) begin
        if (v[k]) begin
          first_set = k[4:0];
        end
      end
    end
  endfunction

  // Selector value that names an implemented event type.
  function is_event;
    input [4:0] code;
    begin
      is_event = (code <= `CAMN_EV_ERROR_OLD);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State.

  reg  [4:0]                event_type_pick_r;
  reg  [1:0]                notify_enable_r [0:NEV-1];
  reg  [`CAMN_NUM_LINE-1:0] line_inv_r;
  reg  [`CAMN_NUM_LINE-1:0] line_prev_r;
  reg                       line_armed_r;
  reg  [`CAMN_ST_W-1:0]     status_r;
  reg  [`CAMN_ST_W-1:0]     mask_r;
  reg  [15:0]               msg_cnt_r;
  reg  [15:0]               lost_cnt_r;
  reg  [`CAMN_TS_W-1:0]     ts_r;
  reg  [NEV-1:0]            pend_r;
  reg  [`CAMN_TS_W-1:0]     ev_ts_r [0:NEV-1];
  reg  [`CAMN_FID_W-1:0]    ev_fid_r [0:NEV-1];
  reg  [`CAMN_ECODE_W-1:0]  err_code_r;

  reg  [NEV-1:0]            hit;
  reg  [NEV-1:0]            enabled;
  reg  [NEV-1:0]            taken;
  reg  [NEV-1:0]            sent_vec;
  reg  [NEV-1:0]            pend_nxt;
  reg  [`CAMN_ST_W-1:0]     status_nxt;
  reg  [31:0]               rd_word;
  reg                       rd_hit;
  reg                       any_lost;
  wire [`CAMN_NUM_LINE-1:0] line_rise;
  wire [`CAMN_NUM_LINE-1:0] line_fall;
  wire                      apb_setup;
  wire                      apb_done;
  wire                      wr_done;
  wire                      rd_take;
  wire                      slot_free;
  wire                      send;
  wire [4:0]                send_idx;
  integer                   i;
  integer                   j;
  integer                   t;
  integer                   w;

  ////////////////////////////////////////////////////////////////////////////
  // Line edges, seen after the inverter like the level view.

  assign line_rise = line_level_view & ~line_prev_r;
  assign line_fall = ~line_level_view & line_prev_r;

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      line_level_view <= {`CAMN_NUM_LINE{1'b0}};
      line_prev_r     <= {`CAMN_NUM_LINE{1'b0}};
      line_armed_r    <= 1'b0;
    end else begin
      line_level_view <= line_in ^ line_inv_r;
      // The first sample after reset seeds the history, so a line that is
      // already high does not report a false rising edge.
      line_prev_r     <= line_armed_r ? line_level_view : (line_in ^ line_inv_r);
      line_armed_r    <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Occurrence vector, indexed by type code.

  always @* begin
    hit = {NEV{1'b0}};
    hit[`CAMN_EV_ACQ_TRIG]   = acq_trigger;
    hit[`CAMN_EV_ACQ_BEGIN]  = acq_begin;
    hit[`CAMN_EV_ACQ_DONE]   = acq_done;
    hit[`CAMN_EV_ACQ_XBEGIN] = acq_xfer_begin;
    hit[`CAMN_EV_ACQ_XDONE]  = acq_xfer_done;
    hit[`CAMN_EV_ACQ_FAULT]  = acquire_fault;
    hit[`CAMN_EV_FRM_TRIG]   = frame_trigger;
    hit[`CAMN_EV_FRM_BEGIN]  = frame_begin;
    hit[`CAMN_EV_FRM_DONE]   = frame_done;
    hit[`CAMN_EV_FRM_XBEGIN] = frame_xfer_begin;
    hit[`CAMN_EV_FRM_XDONE]  = frame_xfer_done;
    hit[`CAMN_EV_EXP_BEGIN]  = exposure_begin;
    hit[`CAMN_EV_EXP_DONE]   = exposure_done;
    // Counter n begin at base+2(n-1), done right after it.
    for (i = 0; i < `CAMN_NUM_CNT; i = i + 1) begin
      hit[`CAMN_EV_CNT_BASE + 2*i]     = counter_begin[i];
      hit[`CAMN_EV_CNT_BASE + 2*i + 1] = counter_done[i];
    end
    for (i = 0; i < `CAMN_NUM_TMR; i = i + 1) begin
      hit[`CAMN_EV_TMR_BASE + 2*i]     = timer_begin[i];
      hit[`CAMN_EV_TMR_BASE + 2*i + 1] = timer_done[i];
    end
    // Line n has rising, falling, either at base+3n.
    for (i = 0; i < `CAMN_NUM_LINE; i = i + 1) begin
      hit[`CAMN_EV_LINE_BASE + 3*i]     = line_rise[i];
      hit[`CAMN_EV_LINE_BASE + 3*i + 1] = line_fall[i];
      hit[`CAMN_EV_LINE_BASE + 3*i + 2] = line_rise[i] | line_fall[i];
    end
    hit[`CAMN_EV_ERROR]     = device_error;
    hit[`CAMN_EV_ERROR_OLD] = device_error;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gating and pending set.

  // One message slot; it frees when the transport takes the message.
  assign slot_free = ~msg_valid | msg_ready;
  assign send      = slot_free & (|pend_r);
  assign send_idx  = first_set(pend_r);

  always @* begin
    enabled  = {NEV{1'b0}};
    sent_vec = {NEV{1'b0}};
    for (j = 0; j < NEV; j = j + 1) begin
      // Legacy value counts as on as well.
      enabled[j] = (notify_enable_r[j] != `CAMN_NOTE_OFF);
    end
    if (send) begin
      sent_vec[send_idx] = 1'b1;
    end
    // Occurrences of disabled types are dropped here.
    taken    = hit & enabled;
    // A fresh occurrence wins over the clear of its own pending bit.
    pend_nxt = (pend_r & ~sent_vec) | taken;
    any_lost = |(hit & enabled & pend_r & ~sent_vec);
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_r     <= {NEV{1'b0}};
      ts_r       <= {`CAMN_TS_W{1'b0}};
      err_code_r <= {`CAMN_ECODE_W{1'b0}};
    end else begin
      pend_r <= pend_nxt;
      ts_r   <= ts_r + 1'b1;
      if (device_error) begin
        err_code_r <= error_code;
      end
    end
  end

  // Time and frame of each occurrence, kept per type until sent.
  always @(posedge sys_clk) begin
    for (t = 0; t < NEV; t = t + 1) begin
      if (sys_rst) begin
        ev_ts_r[t]  <= {`CAMN_TS_W{1'b0}};
        ev_fid_r[t] <= {`CAMN_FID_W{1'b0}};
      end else if (taken[t] & (~pend_r[t] | sent_vec[t])) begin
        ev_ts_r[t]  <= ts_r;
        ev_fid_r[t] <= frame_identifier;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Message port.

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      msg_valid     <= 1'b0;
      msg_type      <= 5'h00;
      msg_timestamp <= {`CAMN_TS_W{1'b0}};
      msg_frame_id  <= {`CAMN_FID_W{1'b0}};
      msg_data      <= {`CAMN_ECODE_W{1'b0}};
    end else if (send) begin
      msg_valid     <= 1'b1;
      msg_type      <= send_idx;
      msg_timestamp <= ev_ts_r[send_idx];
      msg_frame_id  <= ev_fid_r[send_idx];
      if ((send_idx == `CAMN_EV_ERROR) || (send_idx == `CAMN_EV_ERROR_OLD)) begin
        msg_data <= err_code_r;
      end else begin
        msg_data <= {`CAMN_ECODE_W{1'b0}};
      end
    end else if (msg_ready) begin
      msg_valid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave: setup, one wait cycle, then completion with pready.

  assign apb_setup = psel & penable & ~pready;
  assign apb_done  = psel & penable & pready;
  assign wr_done   = apb_done & pwrite;
  // Status clears at the edge that captures it, so no later set is lost.
  assign rd_take   = apb_setup & ~pwrite;

  always @* begin
    rd_word = 32'h0000_0000;
    rd_hit  = 1'b1;
    case (paddr)
      `CAMN_OFF_PICK: begin
        rd_word[4:0] = event_type_pick_r;
      end
      `CAMN_OFF_NOTIFY: begin
        if (is_event(event_type_pick_r)) begin
          rd_word[1:0] = notify_enable_r[event_type_pick_r];
        end
      end
      `CAMN_OFF_LINE_INV: begin
        rd_word[`CAMN_NUM_LINE-1:0] = line_inv_r;
      end
      `CAMN_OFF_LINE_LVL: begin
        rd_word[`CAMN_NUM_LINE-1:0] = line_level_view;
      end
      `CAMN_OFF_STATUS: begin
        rd_word[`CAMN_ST_W-1:0] = status_r;
      end
      `CAMN_OFF_MASK: begin
        rd_word[`CAMN_ST_W-1:0] = mask_r;
      end
      `CAMN_OFF_MSG_CNT: begin
        rd_word[15:0] = msg_cnt_r;
      end
      `CAMN_OFF_LOST_CNT: begin
        rd_word[15:0] = lost_cnt_r;
      end
      default: begin
        rd_hit = 1'b0;
      end
    endcase
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= apb_setup;
      if (apb_setup) begin
        prdata  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr <= ~rd_hit;
      end else begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Writable registers.

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      event_type_pick_r <= 5'h00;
      line_inv_r        <= {`CAMN_NUM_LINE{1'b0}};
      mask_r            <= {`CAMN_ST_W{1'b0}};
      for (w = 0; w < NEV; w = w + 1) begin
        notify_enable_r[w] <= `CAMN_NOTE_OFF;
      end
    end else if (wr_done) begin
      case (paddr)
        `CAMN_OFF_PICK: begin
          event_type_pick_r <= pwdata[4:0];
        end
        `CAMN_OFF_NOTIFY: begin
          // Only implemented types and defined values are stored.
          if (is_event(event_type_pick_r) && (pwdata[1:0] != 2'h3)) begin
            notify_enable_r[event_type_pick_r] <= pwdata[1:0];
          end
        end
        `CAMN_OFF_LINE_INV: begin
          line_inv_r <= pwdata[`CAMN_NUM_LINE-1:0];
        end
        `CAMN_OFF_MASK: begin
          mask_r <= pwdata[`CAMN_ST_W-1:0];
        end
        default: begin
          mask_r <= mask_r;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status, counters and interrupt.

  always @* begin
    status_nxt = status_r;
    if (rd_take && (paddr == `CAMN_OFF_STATUS)) begin
      status_nxt = {`CAMN_ST_W{1'b0}};
    end
    // New events win over the read clear.
    if (send) begin
      status_nxt[`CAMN_ST_SENT] = 1'b1;
    end
    if (any_lost) begin
      status_nxt[`CAMN_ST_LOST] = 1'b1;
    end
  end

  always @(posedge sys_clk) begin
    if (sys_rst) begin
      status_r   <= {`CAMN_ST_W{1'b0}};
      msg_cnt_r  <= 16'h0000;
      lost_cnt_r <= 16'h0000;
      irq        <= 1'b0;
    end else begin
      status_r <= status_nxt;
      irq      <= |(status_nxt & mask_r);
      if (send) begin
        msg_cnt_r <= msg_cnt_r + 16'h0001;
      end
      if (any_lost) begin
        lost_cnt_r <= lost_cnt_r + 16'h0001;
      end
    end
  end

endmodule // camn_notifier

// >>> verification/camn_properties.sv
`timescale 1ns/100ps
`include "camn_regs.vh"

module camn_props (
  // Clock and reset.
  input wire                     sys_clk,
  input wire                     sys_rst,
  // APB slave side.
  input wire                     psel,
  input wire                     penable,
  input wire                     pwrite,
  input wire [11:0]              paddr,
  input wire [31:0]              pwdata,
  input wire [31:0]              prdata,
  input wire                     pready,
  input wire                     pslverr,
  // Message port and interrupt.
  input wire                     msg_ready,
  input wire                     msg_valid,
  input wire [4:0]               msg_type,
  input wire [`CAMN_TS_W-1:0]    msg_timestamp,
  input wire [`CAMN_FID_W-1:0]   msg_frame_id,
  input wire [`CAMN_ECODE_W-1:0] msg_data,
  input wire                     irq
);
  // Goes high once software has tried to switch any notification on.
  reg en_seen_r;

  always @(posedge sys_clk) begin
    if (sys_rst)
      en_seen_r <= 1'b0;
    else if (psel && penable && pready && pwrite && paddr == 12'h004 && pwdata[1:0] != 2'h0)
      en_seen_r <= 1'b1;
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (sys_rst);

  a_access_answer: assert property (psel && penable && !pready |=> pready)
    else $error("no answer one cycle after the access edge");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_decode: assert property (pready |->
    pslverr == (paddr > 12'h01c || paddr[1:0] != 2'h0))
    else $error("pslverr does not match address decode");
  a_err_gated: assert property (pslverr |-> pready)
    else $error("pslverr outside the answer cycle");
  a_read_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata nonzero outside the answer cycle");
  a_msg_hold: assert property (msg_valid && !msg_ready |=> msg_valid &&
    $stable({msg_type, msg_timestamp, msg_frame_id, msg_data}))
    else $error("message dropped or changed while stalled");
  a_msg_data: assert property (msg_valid && msg_type < 5'h1b |-> msg_data == 8'h0)
    else $error("extra data on a non-error message");
  a_type_range: assert property (msg_valid |-> msg_type <= 5'h1c)
    else $error("message type outside the code table");
  a_off_silent: assert property (!en_seen_r |-> !msg_valid)
    else $error("message before any notification was enabled");
  a_reset_quiet: assert property (disable iff (1'b0) sys_rst |=> !msg_valid && !irq && !pready)
    else $error("outputs active after reset");

  cover property (pready && pslverr);
  cover property (msg_valid && !msg_ready);
  cover property (msg_valid && msg_type == 5'h1c);
  cover property ($rose(irq));
endmodule // camn_props

// >>> verification/camn_host_model.sv
`timescale 1ns/100ps
`include "camn_regs.vh"

module camn_host (
  // Clock and reset.
  input wire                     sys_clk,
  input wire                     sys_rst,
  // Message port.
  input wire                     msg_valid,
  input wire [4:0]               msg_type,
  input wire [`CAMN_TS_W-1:0]    msg_timestamp,
  input wire [`CAMN_FID_W-1:0]   msg_frame_id,
  input wire [`CAMN_ECODE_W-1:0] msg_data,
  // Bench control.
  input wire                     stall,
  output reg                     msg_ready
);
  // Received messages packed as type, timestamp, frame id, data.
  logic [60:0] got_q[$];

  always @(posedge sys_clk) begin
    msg_ready <= !sys_rst && !stall;
    if (!sys_rst && msg_valid && msg_ready)
      got_q.push_back({msg_type, msg_timestamp, msg_frame_id, msg_data});
  end
endmodule // camn_host

// >>> verification/tb.sv
`timescale 1ns/100ps
`include "camn_regs.vh"

module tb;
  logic        sys_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, msg_timestamp, ts_model, exp_ts, rd;
  logic        pready, pslverr, msg_ready, msg_valid, irq, er, stall = 0, device_error = 0;
  logic [20:0] occ = '0;
  logic [1:0]  line_in = '0, line_level_view;
  logic [7:0]  error_code = '0, msg_data;
  logic [15:0] frame_identifier = '0, msg_frame_id;
  logic [4:0]  msg_type;
  logic [60:0] m;
  int          mismatches = 0, num_checks = 0;

  always #2 sys_clk = ~sys_clk;
  always @(posedge sys_clk) ts_model <= sys_rst ? 32'h0 : ts_model + 32'h1;

  camn_notifier dut (
    .sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .acq_trigger(occ[0]), .acq_begin(occ[1]), .acq_done(occ[2]), .acq_xfer_begin(occ[3]),
    .acq_xfer_done(occ[4]), .acquire_fault(occ[5]), .frame_trigger(occ[6]),
    .frame_begin(occ[7]), .frame_done(occ[8]), .frame_xfer_begin(occ[9]),
    .frame_xfer_done(occ[10]), .exposure_begin(occ[11]), .exposure_done(occ[12]),
    .counter_begin({occ[15], occ[13]}), .counter_done({occ[16], occ[14]}),
    .timer_begin({occ[19], occ[17]}), .timer_done({occ[20], occ[18]}), .line_in,
    .device_error, .error_code, .frame_identifier, .msg_ready, .msg_valid, .msg_type,
    .msg_timestamp, .msg_frame_id, .msg_data, .irq, .line_level_view);

  camn_host u_host (.sys_clk, .sys_rst, .msg_valid, .msg_type, .msg_timestamp, .msg_frame_id,
    .msg_data, .stall, .msg_ready);

  ////////////////////////////////////////
  task end_sim;
    $display("Checks %0d, mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      $display("[FAIL] apb pready expected 1 seen %b", pready);
      mismatches++;
      end_sim;
    end
  endtask

  task wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task rdc(input string nm, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(nm, exp, rd);
  endtask

  task enable(input logic [4:0] c, input logic [1:0] v);
    wr(12'h000, {27'h0, c});
    wr(12'h004, {30'h0, v});
  endtask

  // The expected timestamp is the free count seen at the edge that samples the pulse.
  task fire(input int c);
    @(posedge sys_clk);
    occ[c] <= 1'b1;
    @(posedge sys_clk);
    exp_ts = ts_model;
    occ <= '0;
  endtask

  task expect_msg(input string nm, input logic [4:0] c, input logic [7:0] d);
    int n;
    n = 0;
    while (u_host.got_q.size() == 0 && n < 50) begin
      @(posedge sys_clk);
      n++;
    end
    if (u_host.got_q.size() == 0) begin
      $display("[FAIL] %s expected %h seen none", nm, c);
      mismatches++;
      end_sim;
    end else begin
      m = u_host.got_q.pop_front();
      chk(nm, {27'h0, c}, {27'h0, m[60:56]});
      chk(nm, {24'h0, d}, {24'h0, m[7:0]});
    end
  endtask

  task quiet(input string nm);
    repeat (10) @(posedge sys_clk);
    chk(nm, 32'h0, u_host.got_q.size());
  endtask

  ////////////////////////////////////////
  task t_reset;
    rdc("selector", 12'h000, 32'h0);
    rdc("notify", 12'h004, 32'h0);
    rdc("mask", 12'h014, 32'h0);
    rdc("unmapped", 12'h020, 32'h0);
    chk("unmapped err", 32'h1, {31'h0, er});
    enable(5'h0c, 2'h1);
    wr(12'h000, 32'h0b);
    rdc("other notify", 12'h004, 32'h0);
    wr(12'h000, 32'h0c);
    rdc("own notify", 12'h004, 32'h1);
  endtask

  task t_expo;
    @(posedge sys_clk);
    frame_identifier <= 16'ha5c3;
    fire(12);
    expect_msg("exposure done", 5'h0c, 8'h0);
    chk("timestamp", exp_ts, m[55:24]);
    chk("frame id", 32'ha5c3, {16'h0, m[23:8]});
  endtask

  task t_drop;
    fire(11);
    quiet("disabled");
    enable(5'h0b, 2'h1);
    quiet("not queued");
    fire(11);
    expect_msg("exposure begin", 5'h0b, 8'h0);
  endtask

  task t_all;
    for (int c = 0; c < 21; c++) begin
      enable(c[4:0], 2'h1);
      fire(c);
      expect_msg("event code", c[4:0], 8'h0);
    end
    quiet("no extras");
  endtask

  task t_lines;
    for (int c = 21; c < 27; c++)
      enable(c[4:0], 2'h1);
    wr(12'h008, 32'h1);
    expect_msg("inverted rise", 5'h15, 8'h0);
    expect_msg("either rise", 5'h17, 8'h0);
    chk("level view", 32'h1, {30'h0, line_level_view});
    rdc("level reg", 12'h00c, 32'h1);
    @(posedge sys_clk);
    line_in <= 2'b01;
    expect_msg("inverted fall", 5'h16, 8'h0);
    expect_msg("either fall", 5'h17, 8'h0);
    @(posedge sys_clk);
    line_in <= 2'b11;
    expect_msg("line1 rise", 5'h18, 8'h0);
    expect_msg("line1 either", 5'h1a, 8'h0);
    @(posedge sys_clk);
    line_in <= 2'b01;
    expect_msg("line1 fall", 5'h19, 8'h0);
    expect_msg("line1 either", 5'h1a, 8'h0);
    quiet("line extras");
  endtask

  task t_error;
    enable(5'h1b, 2'h2);
    rdc("legacy value", 12'h004, 32'h2);
    wr(12'h004, 32'h3);
    rdc("refused value", 12'h004, 32'h2);
    enable(5'h1c, 2'h1);
    @(posedge sys_clk);
    error_code <= 8'h5a;
    device_error <= 1'b1;
    @(posedge sys_clk);
    device_error <= 1'b0;
    expect_msg("error", 5'h1b, 8'h5a);
    expect_msg("old error", 5'h1c, 8'h5a);
  endtask

  task t_irq;
    wr(12'h014, 32'h3);
    apb(1'b0, 12'h010, 32'h0);
    repeat (2) @(posedge sys_clk);
    chk("irq idle", 32'h0, {31'h0, irq});
    @(posedge sys_clk);
    stall <= 1'b1;
    repeat (3) fire(6);
    repeat (2) @(posedge sys_clk);
    chk("irq raised", 32'h1, {31'h0, irq});
    rdc("status", 12'h010, 32'h3);
    rdc("lost count", 12'h01c, 32'h1);
    rdc("message count", 12'h018, 32'h22);
    repeat (2) @(posedge sys_clk);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(12'h014, 32'h0);
    @(posedge sys_clk);
    stall <= 1'b0;
    expect_msg("held message", 5'h06, 8'h0);
    repeat (10) @(posedge sys_clk);
    u_host.got_q.delete();
  endtask

  initial begin
    repeat (3) @(posedge sys_clk);
    sys_rst <= 1'b0;
    t_reset;
    t_expo;
    t_drop;
    t_all;
    t_lines;
    t_error;
    t_irq;
    end_sim;
  end
endmodule // tb

bind camn_notifier camn_props u_props (.sys_clk, .sys_rst, .psel, .penable, .pwrite, .paddr,
  .pwdata, .prdata, .pready, .pslverr, .msg_ready, .msg_valid, .msg_type, .msg_timestamp,
  .msg_frame_id, .msg_data, .irq);
